// file: src/eew_fifo.sv
// Write request FIFO between page commit and array write port
`timescale 1ns/1ns
`include "eew_params.svh"
module eew_fifo #(
  parameter int WIDTH = `EEW_FIFO_WIDTH,
  parameter int DEPTH = `EEW_FIFO_DEPTH
) (
  input wire logic core_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic in_valid, // Push request
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Pushed word
  output logic out_valid, // Word available
  input wire logic out_ready, // Consumer takes word
  output logic [WIDTH-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } eew_fifo_t;

  eew_fifo_t r;
  eew_fifo_t n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Handshakes; depth is a power of two so pointers wrap by themselves
  assign in_ready = r.count != (AW+1)'(DEPTH);
  assign out_valid = r.count != '0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[r.rd_ptr];

  // Pointer and fill level update
  always_comb
  begin
    n = r;
    if (push)
      n.wr_ptr = r.wr_ptr + 1'b1;
    if (pop)
      n.rd_ptr = r.rd_ptr + 1'b1;
    n.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register and storage
  always_ff @(posedge core_clk)
  begin
    if (reset)
      r <= '0;
    else
      r <= n;
    if (push)
      mem[r.wr_ptr] <= in_data;
  end
endmodule : eew_fifo

// file: src/eew_params.svh
// Constants for the serial EEPROM two-wire slave front end
`ifndef EEW_PARAMS_SVH
`define EEW_PARAMS_SVH
`define EEW_CLK_PERIOD_NS 10
`define EEW_TWC_NS 5000000
`define EEW_TWC_CYCLES (`EEW_TWC_NS / `EEW_CLK_PERIOD_NS)
`define EEW_TIMER_W 20
`define EEW_CODE_ARRAY 4'ha
`define EEW_CODE_WPREG 4'h6
`define EEW_PAGE_BYTES 16
`define EEW_FIFO_DEPTH 8
`define EEW_FIFO_WIDTH 16
`define EEW_SYNC_BITS 6
`define EEW_PINS_RST 6'h30
`define EEW_LAST_BIT 3'h7
`define EEW_LAST_SLOT 4'hf
`endif

// file: src/eew_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ns
`include "eew_params.svh"
module eew_pin_sync #(
  parameter int WIDTH = `EEW_SYNC_BITS,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] din, // Raw pin levels
  output logic [WIDTH-1:0] dout // Filtered levels
);
  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] out;
  } eew_sync_t;

  eew_sync_t r;
  eew_sync_t n;

  // A bit only moves once stages two and three agree; stage one feeds stage two only
  always_comb
  begin
    n = r;
    n.ff1 = din;
    n.ff2 = r.ff1;
    n.ff3 = r.ff2;
    n.out = (r.ff2 & ~(r.ff2 ^ r.ff3)) | (r.out & (r.ff2 ^ r.ff3));
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (reset)
      r <= '{ff1: RST_VAL, ff2: RST_VAL, ff3: RST_VAL, out: RST_VAL};
    else
      r <= n;
  end

  assign dout = r.out;
endmodule : eew_pin_sync

// file: src/eew_pkg.sv
// Types shared by the serial EEPROM two-wire slave front end
`include "eew_params.svh"
package eew_pkg;
  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_CTRL = 10'h002,
    S_ACK_CTRL = 10'h004,
    S_ADDR = 10'h008,
    S_ACK_ADDR = 10'h010,
    S_DATA = 10'h020,
    S_ACK_DATA = 10'h040,
    S_TX = 10'h080,
    S_TX_ACK = 10'h100,
    S_IGNORE = 10'h200
  } eew_state_t;

  typedef enum logic [2:0] {
    C_IDLE = 3'h1,
    C_PUSH = 3'h2,
    C_WAIT = 3'h4
  } eew_commit_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } eew_wr_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [2:0] cs;
    logic wp;
  } eew_pins_t;

  typedef struct packed {
    eew_state_t st;
    eew_commit_t cmt;
    logic scl_q;
    logic sda_q;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic byte_done;
    logic drive;
    logic rw;
    logic wpr_cmd;
    logic data_seen;
    logic sw_prot;
    logic busy;
    logic [7:0] ptr;
    logic [15:0][7:0] page;
    logic [15:0] mask;
    logic [3:0] cidx;
    logic [`EEW_TIMER_W-1:0] timer;
  } eew_core_t;
endpackage : eew_pkg

// file: src/eew_slave.sv
// Two-wire slave front end of a 256-byte serial EEPROM with page write and protection
//
// Summary of operation
// RULE1 - Master drives clock, Start and Stop
// RULE2 - Transfers begin only on idle bus
// RULE3 - Data changes only while clock low
// RULE4 - Data fall during clock high: Start
// RULE5 - Data rise during clock high: Stop
// RULE6 - One clock pulse per sampled bit
// RULE7 - Receiver holds data low on ninth pulse
// RULE8 - Master supplies every acknowledge clock pulse
// RULE9 - Read ends on master no-ack; release line
// RULE10 - First byte is control: code, selects, direction
// RULE11 - Respond only when chip selects match
// RULE12 - Last control bit: one read, zero write
// RULE13 - Never ack protect-register code with read
// RULE14 - Second write byte loads address pointer
// RULE15 - Stop after data starts write cycle
// RULE16 - No acknowledge while programming runs
// RULE17 - Protected writes acked, timed, not stored
// RULE18 - Page buffer takes fifteen more bytes
// RULE19 - Increment low pointer nibble only
// RULE20 - Overflow keeps only the last sixteen
// RULE21 - Protect pin high blocks all writes
// RULE22 - Register set locks lower half forever
// RULE23 - After set, refuse protect-register code
// RULE24 - Upper half guarded only by pin
// RULE25 - Write cycle length is a parameter
`timescale 1ns/1ns
`include "eew_params.svh"
module eew_slave #(
  parameter int TWC_CYCLES = `EEW_TWC_CYCLES,
  parameter int FIFO_DEPTH = `EEW_FIFO_DEPTH
) (
  input wire logic core_clk, // System clock, 100 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire logic scl_in, // Serial clock pin from master
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive value, always low
  output logic sda_oe, // High while pulling data low
  input wire logic chip_select_bit0_pin, // Chip select strap 0
  input wire logic chip_select_bit1_pin, // Chip select strap 1
  input wire logic chip_select_bit2_pin, // Chip select strap 2
  input wire logic write_protect_pin, // High protects the whole array
  output logic [7:0] mem_rd_addr, // Array read address
  input wire logic [7:0] mem_rd_data, // Array read data, asynchronous
  output logic mem_wr_valid, // Array write request
  input wire logic mem_wr_ready, // Array accepts write
  output eew_pkg::eew_wr_req_t mem_wr_req, // Array write address and data
  output logic busy, // Internal write cycle running
  output logic sw_protect_set // Lower half locked
);
  import eew_pkg::*;

  localparam eew_core_t CORE_RST = '{st: S_IDLE, cmt: C_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
  localparam logic [`EEW_TIMER_W-1:0] TWC_LOAD = `EEW_TIMER_W'(TWC_CYCLES);

  eew_core_t r;
  eew_core_t n;
  eew_pins_t pins;
  logic [`EEW_SYNC_BITS-1:0] pins_raw;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [3:0] ctrl_code;
  logic cs_match;
  logic ctrl_ack;
  logic [7:0] push_addr;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [`EEW_FIFO_WIDTH-1:0] fifo_out;

  // A location is locked by the pin everywhere, by the register only below 80h
  function automatic logic is_protected(input logic [7:0] addr, input logic hw, input logic sw);
    return hw | (sw & ~addr[7]);
  endfunction : is_protected

  // Every pin from outside crosses into the core clock through the filter
  eew_pin_sync #(
    .WIDTH(`EEW_SYNC_BITS),
    .RST_VAL(`EEW_PINS_RST)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .din({scl_in, sda_in, chip_select_bit2_pin, chip_select_bit1_pin, chip_select_bit0_pin, write_protect_pin}),
    .dout(pins_raw)
  );

  assign pins = eew_pins_t'(pins_raw);

  // Edge and bus condition detection on the filtered lines
  // RULE4 start seen
  assign start_det = pins.scl & r.scl_q & r.sda_q & ~pins.sda;
  // RULE5 stop seen
  assign stop_det = pins.scl & r.scl_q & ~r.sda_q & pins.sda;
  assign scl_rise = pins.scl & ~r.scl_q;
  assign scl_fall = ~pins.scl & r.scl_q;

  // Control byte decode
  // RULE10 RULE11 RULE13 RULE16 RULE23 control acceptance
  assign ctrl_code = r.shift[7:4];
  assign cs_match = r.shift[3:1] == pins.cs;
  assign ctrl_ack = cs_match & ~r.busy & ((ctrl_code == `EEW_CODE_ARRAY) |
                    ((ctrl_code == `EEW_CODE_WPREG) & ~r.shift[0] & ~r.sw_prot));

  // Commit walks the page buffer; protected bytes are skipped, not pushed
  // RULE17 RULE21 RULE22 RULE24 protection filter
  assign push_addr = {r.ptr[7:4], r.cidx};
  assign fifo_in_valid = (r.cmt == C_PUSH) & r.mask[r.cidx] & ~is_protected(push_addr, pins.wp, r.sw_prot);

  // Buffer between commit and array; a slow array stretches the busy time
  eew_fifo #(
    .WIDTH(`EEW_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({push_addr, r.page[r.cidx]}),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data(fifo_out)
  );

  // Next state: commit engine, then bus engine
  always_comb
  begin
    logic load_tx;
    load_tx = 1'b0;
    n = r;
    n.scl_q = pins.scl;
    n.sda_q = pins.sda;
    if (r.timer != '0)
      n.timer = r.timer - `EEW_TIMER_W'(1);
    // Commit stalls on a full FIFO so no byte is dropped
    unique case (r.cmt)
      C_IDLE: n.cmt = C_IDLE;
      C_PUSH:
      begin
        if (!fifo_in_valid || fifo_in_ready)
        begin
          if (r.cidx == `EEW_LAST_SLOT)
          begin
            n.cmt = C_WAIT;
            n.mask = '0;
          end
          else
            n.cidx = r.cidx + 4'h1;
        end
      end
      C_WAIT:
      begin
        if (r.timer == '0 && !mem_wr_valid) // Queue drained too, else a slow array outlives busy
        begin
          n.cmt = C_IDLE;
          n.busy = 1'b0;
        end
      end
      default: n.cmt = C_IDLE;
    endcase
    if (start_det)
    begin
      n.st = S_CTRL;
      n.bit_cnt = '0;
      n.byte_done = 1'b0;
      n.drive = 1'b0;
      n.data_seen = 1'b0;
    end
    else if (stop_det)
    begin
      // RULE15 RULE25 stop starts the timed write
      if (r.data_seen && !r.busy)
      begin
        n.busy = 1'b1;
        n.timer = TWC_LOAD;
        n.cidx = '0;
        n.cmt = r.wpr_cmd ? C_WAIT : C_PUSH;
        // RULE22 the pin vetoes setting the lock
        if (r.wpr_cmd && !pins.wp)
          n.sw_prot = 1'b1;
      end
      n.st = S_IDLE;
      n.drive = 1'b0;
      n.byte_done = 1'b0;
      n.data_seen = 1'b0;
    end
    else
    begin
      // RULE6 bits sampled on clock rise
      if (scl_rise && (r.st == S_CTRL || r.st == S_ADDR || r.st == S_DATA))
      begin
        n.shift = {r.shift[6:0], pins.sda};
        n.bit_cnt = r.bit_cnt + 3'h1;
        if (r.bit_cnt == `EEW_LAST_BIT)
          n.byte_done = 1'b1;
      end
      unique case (r.st)
        S_IDLE, S_IGNORE: n.st = r.st;
        S_CTRL:
        begin
          // RULE7 ack driven from the clock fall after the eighth bit
          if (scl_fall && r.byte_done)
          begin
            n.byte_done = 1'b0;
            n.bit_cnt = '0;
            if (ctrl_ack)
            begin
              n.st = S_ACK_CTRL;
              n.drive = 1'b1;
              n.wpr_cmd = ctrl_code == `EEW_CODE_WPREG;
              // RULE12 direction bit
              n.rw = r.shift[0];
              n.mask = '0;
            end
            else
              n.st = S_IGNORE;
          end
        end
        S_ACK_CTRL:
        begin
          if (scl_fall)
          begin
            n.drive = 1'b0;
            if (r.rw)
              load_tx = 1'b1;
            else
              n.st = S_ADDR;
          end
        end
        S_ADDR:
        begin
          if (scl_fall && r.byte_done)
          begin
            n.byte_done = 1'b0;
            n.bit_cnt = '0;
            n.st = S_ACK_ADDR;
            n.drive = 1'b1;
            // RULE14 word address into the pointer
            if (!r.wpr_cmd)
              n.ptr = r.shift;
          end
        end
        S_DATA:
        begin
          if (scl_fall && r.byte_done)
          begin
            n.byte_done = 1'b0;
            n.bit_cnt = '0;
            // RULE17 data always acknowledged
            n.st = S_ACK_DATA;
            n.drive = 1'b1;
            n.data_seen = 1'b1;
            // RULE18 RULE19 RULE20 buffer slot by low nibble, wrap overwrites oldest
            if (!r.wpr_cmd)
            begin
              n.page[r.ptr[3:0]] = r.shift;
              n.mask[r.ptr[3:0]] = 1'b1;
              n.ptr = {r.ptr[7:4], r.ptr[3:0] + 4'h1};
            end
          end
        end
        S_ACK_ADDR, S_ACK_DATA:
        begin
          if (scl_fall)
          begin
            n.drive = 1'b0;
            n.st = S_DATA;
          end
        end
        S_TX:
        begin
          // RULE3 data moves only on clock fall
          if (scl_fall)
          begin
            if (r.bit_cnt == `EEW_LAST_BIT)
            begin
              n.drive = 1'b0;
              n.bit_cnt = '0;
              n.st = S_TX_ACK;
            end
            else
            begin
              n.shift = {r.shift[6:0], 1'b0};
              n.bit_cnt = r.bit_cnt + 3'h1;
              n.drive = ~r.shift[6];
            end
          end
        end
        S_TX_ACK:
        begin
          // RULE9 no-ack from master ends the read with the line released
          if (scl_rise)
          begin
            if (pins.sda)
              n.st = S_IGNORE;
            else
              n.byte_done = 1'b1;
          end
          if (scl_fall && r.byte_done)
          begin
            n.byte_done = 1'b0;
            load_tx = 1'b1;
          end
        end
        default: n.st = S_IDLE;
      endcase
      // Next read byte: the pointer runs over the whole array
      if (load_tx)
      begin
        n.shift = mem_rd_data;
        n.ptr = r.ptr + 8'h01;
        n.drive = ~mem_rd_data[7];
        n.bit_cnt = '0;
        n.st = S_TX;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (reset)
      r <= CORE_RST;
    else
      r <= n;
  end

  // Open-drain data pin and status outputs, all but the constant sda_out from flops
  assign sda_out = 1'b0;
  assign sda_oe = r.drive;
  assign mem_rd_addr = r.ptr;
  assign mem_wr_req = eew_wr_req_t'(fifo_out);
  assign busy = r.busy;
  assign sw_protect_set = r.sw_prot;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_ctrl_end;
    scl_fall && r.byte_done && r.st == S_CTRL;
  endsequence

  sequence s_data_end;
    scl_fall && r.byte_done && r.st == S_DATA;
  endsequence

  a_start_ctrl: assert property (start_det |=> r.st == S_CTRL && r.bit_cnt == 3'h0) // RULE4
    else $error("Start did not open a control byte");
  a_stop_idle: assert property (stop_det |=> r.st == S_IDLE && !r.drive) // RULE5
    else $error("Stop did not return to idle");
  a_sample_bit: assert property (scl_rise && r.st == S_CTRL && !start_det |=> r.shift[0] == $past(pins.sda)) // RULE6
    else $error("Bit not sampled on clock rise");
  a_ctrl_ack: assert property (s_ctrl_end ##0 ctrl_ack |=> r.drive ##1 (r.drive || !pins.scl || stop_det)) // RULE7
    else $error("Matched control byte not acknowledged");
  a_cs_mismatch: assert property (s_ctrl_end ##0 !cs_match |=> r.st == S_IGNORE && !r.drive) // RULE11
    else $error("Acknowledged with wrong chip select");
  a_wpr_read: assert property (s_ctrl_end ##0 (ctrl_code == 4'h6 && r.shift[0]) |=> !r.drive) // RULE13
    else $error("Protect register read acknowledged");
  a_busy_nak: assert property (s_ctrl_end ##0 r.busy |=> !r.drive) // RULE16
    else $error("Acknowledged during write cycle");
  a_wpr_lock: assert property (s_ctrl_end ##0 (r.sw_prot && ctrl_code == 4'h6) |=> !r.drive) // RULE23
    else $error("Protect code acknowledged after lock");
  a_data_ack: assert property (s_data_end |=> r.drive && r.st == S_ACK_DATA) // RULE17
    else $error("Data byte not acknowledged");
  a_page_wrap: assert property (s_data_end ##0 !r.wpr_cmd |=>
      r.ptr[7:4] == $past(r.ptr[7:4]) && r.ptr[3:0] == $past(r.ptr[3:0]) + 4'h1) // RULE19
    else $error("Pointer left the page");
  a_stop_commit: assert property (stop_det && r.data_seen && !r.busy |=> r.busy [*2]) // RULE15
    else $error("Stop did not start the write cycle");
  a_upper_pin: assert property (fifo_in_valid && push_addr[7] |-> !pins.wp) // RULE24
    else $error("Upper half written with pin high");
  a_lower_lock: assert property (fifo_in_valid && !push_addr[7] |-> !r.sw_prot && !pins.wp) // RULE22
    else $error("Locked lower half written");
  a_nak_release: assert property (r.st == S_TX_ACK && scl_rise && pins.sda |=> r.st == S_IGNORE && !r.drive) // RULE9
    else $error("Line not released after no-ack");
  a_drive_low: assert property ($changed(r.drive) && !$past(start_det) && !$past(stop_det) |-> !pins.scl) // RULE3
    else $error("Data drive changed with clock high");
endmodule : eew_slave

// file: verif/eew_bus_master.sv
// Behavioural two-wire bus master that paces the serial bus from the system clock
`timescale 1ns/1ns
module eew_bus_master (
  input wire logic core_clk, // System clock that paces each bus phase
  input wire logic sda_line, // Resolved level of the data wire
  output logic scl, // Serial clock, only ever driven here
  output logic sda_oe // High while the master pulls data low
);
  // master owns the clock and starts from an idle, released bus
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // Phases last 4 or 8 core cycles so the pin filters always see them
  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask : gap

  // data falls while clock is high, also serves as a repeated start
  task automatic start;
    gap(4);
    sda_oe = 1'b0;
    gap(4);
    scl = 1'b1;
    gap(8);
    sda_oe = 1'b1;
    gap(8);
    scl = 1'b0;
  endtask : start

  // data rises while clock is high, bus left idle afterwards
  task automatic stop;
    gap(4);
    sda_oe = 1'b1;
    gap(4);
    scl = 1'b1;
    gap(8);
    sda_oe = 1'b0;
    gap(8);
  endtask : stop

  // data moves mid low phase; sampled late in the single high pulse
  task automatic xbit(input logic b, output logic r);
    gap(4);
    sda_oe = ~b;
    gap(4);
    scl = 1'b1;
    gap(8);
    r = sda_line;
    scl = 1'b0;
  endtask : xbit

  // master releases data and clocks the ninth pulse for the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask : wbyte

  // a no-ack on the last byte tells the device to let go of the line
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      xbit(1'b1, d[i]);
    xbit(~more, r);
  endtask : rbyte
endmodule : eew_bus_master

// file: verif/eew_slave_tb.sv
// Self-checking bench for the two-wire EEPROM slave front end
`timescale 1ns/1ns
module eew_slave_tb;
  import eew_pkg::*;
  localparam int TWC = 50;
  logic core_clk;
  logic reset;
  logic scl;
  logic m_oe;
  logic sda_line;
  logic [2:0] cs_pins;
  logic wp_pin;
  logic [7:0] mem_rd_addr;
  logic [7:0] mem_rd_data;
  logic mem_wr_valid;
  logic mem_wr_ready;
  eew_wr_req_t mem_wr_req;
  logic sda_out;
  logic sda_oe;
  logic busy;
  logic sw_protect_set;
  logic [7:0] mem [256];
  int fail_count;
  int n_checks;
  logic ack;
  logic [7:0] rd;

  // Pulled-up data wire: low while either party drives
  assign sda_line = ~(m_oe | sda_oe);
  // Array model answers reads at once; writes land when taken
  assign mem_rd_data = mem[mem_rd_addr];
  always @(posedge core_clk)
    if (mem_wr_valid && mem_wr_ready)
      mem[mem_wr_req.addr] <= mem_wr_req.data;

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  eew_slave #(.TWC_CYCLES(TWC), .FIFO_DEPTH(8)) dut (
    .core_clk(core_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit0_pin(cs_pins[0]),
    .chip_select_bit1_pin(cs_pins[1]), .chip_select_bit2_pin(cs_pins[2]),
    .write_protect_pin(wp_pin), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_req(mem_wr_req),
    .busy(busy), .sw_protect_set(sw_protect_set));

  eew_bus_master m (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_oe(m_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One write command; address and data follow only when the control byte is acked
  task automatic wr_cmd(input logic [3:0] code, input logic [7:0] a, input int n,
                        input logic [7:0] d0, output logic cack);
    logic k;
    m.start();
    m.wbyte({code, cs_pins, 1'b0}, cack);
    if (cack === 1'b1)
    begin
      m.wbyte(a, k);
      chk(k, 1'b1);
      for (int i = 0; i < n; i++)
      begin
        m.wbyte(d0 + 8'(i), k);
        chk(k, 1'b1);
      end
    end
    m.stop();
  endtask : wr_cmd

  // Bounded wait for the write cycle to end
  task automatic wait_idle;
    int c = 0;
    while (busy !== 1'b0 && c < 5000)
    begin
      @(negedge core_clk);
      c++;
    end
    chk(busy, 1'b0);
  endtask : wait_idle

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  // Whole run is near 10k cycles; five times that means a hang
  initial
  begin
    repeat (50000) @(posedge core_clk);
    fail_count++;
    close_out();
  end

  initial
  begin
    fail_count = 0;
    n_checks = 0;
    reset = 1'b1;
    cs_pins = 3'h5;
    wp_pin = 1'b0;
    mem_wr_ready = 1'b1;
    for (int i = 0; i < 256; i++)
      mem[i] = ~8'(i);
    repeat (16) @(negedge core_clk);
    reset = 1'b0;
    chk({busy, sda_oe, sw_protect_set, mem_wr_valid, sda_out}, 5'h00);
    chk(mem_rd_addr, 8'h00);
    repeat (10) @(negedge core_clk);
    $display("test reset done");

    wr_cmd(4'ha, 8'h85, 1, 8'h3c, ack);
    chk(ack, 1'b1);
    chk(busy, 1'b1);
    wait_idle();
    chk(mem[8'h85], 8'h3c);
    $display("test byte write done");

    // Each select bit wrong in the control byte in turn, pins unchanged, then a foreign code
    for (int b = 0; b < 3; b++)
    begin
      m.start();
      m.wbyte({4'ha, cs_pins ^ (3'h1 << b), 1'b0}, ack);
      m.stop();
      chk(ack, 1'b0);
    end
    wr_cmd(4'h5, 8'h00, 1, 8'h00, ack);
    chk(ack, 1'b0);
    m.start();
    m.wbyte({4'h6, cs_pins, 1'b1}, ack);
    m.stop();
    chk(ack, 1'b0);
    chk(mem[8'h00], 8'hff);
    $display("test refusals done");

    // Eighteen bytes from slot e with the array stalled so the queue fills
    mem_wr_ready = 1'b0;
    wr_cmd(4'ha, 8'h9e, 18, 8'h01, ack);
    chk(ack, 1'b1);
    m.start();
    m.wbyte({4'ha, cs_pins, 1'b0}, ack);
    m.stop();
    chk(ack, 1'b0);
    chk({busy, mem_wr_valid}, 2'h3);
    mem_wr_ready = 1'b1;
    wait_idle();
    chk(mem_wr_valid, 1'b0);
    for (int s = 0; s < 16; s++)
      chk(mem[8'h90 + 8'(s)], 8'(s + 3));
    $display("test page write done");

    // Address set then repeated start into a two-byte read
    m.start();
    m.wbyte({4'ha, cs_pins, 1'b0}, ack);
    m.wbyte(8'h9e, ack);
    chk(ack, 1'b1);
    m.start();
    m.wbyte({4'ha, cs_pins, 1'b1}, ack);
    chk(ack, 1'b1);
    m.rbyte(1'b1, rd);
    chk(rd, 8'h11);
    m.rbyte(1'b0, rd);
    chk(rd, 8'h12);
    m.gap(4);
    chk(sda_oe, 1'b0);
    m.stop();
    chk(busy, 1'b0);
    $display("test random read done");

    wp_pin = 1'b1;
    wr_cmd(4'ha, 8'h10, 1, 8'h77, ack);
    chk(ack, 1'b1);
    chk(busy, 1'b1);
    wait_idle();
    chk(mem[8'h10], 8'hef);
    wr_cmd(4'h6, 8'h00, 1, 8'h00, ack);
    chk(ack, 1'b1);
    wait_idle();
    chk(sw_protect_set, 1'b0);
    wp_pin = 1'b0;
    wr_cmd(4'h6, 8'h00, 1, 8'h00, ack);
    chk(ack, 1'b1);
    wait_idle();
    chk(sw_protect_set, 1'b1);
    wr_cmd(4'h6, 8'h00, 1, 8'h00, ack);
    chk(ack, 1'b0);
    wr_cmd(4'ha, 8'h7f, 1, 8'h55, ack);
    chk(ack, 1'b1);
    wait_idle();
    chk(mem[8'h7f], 8'h80);
    wr_cmd(4'ha, 8'h80, 1, 8'h66, ack);
    wait_idle();
    chk(mem[8'h80], 8'h66);
    wp_pin = 1'b1;
    wr_cmd(4'ha, 8'h81, 1, 8'h44, ack);
    wait_idle();
    chk(mem[8'h81], 8'h7e);
    $display("test protection done");
    close_out();
  end
endmodule : eew_slave_tb
